// ### dapo_pkg.sv
// Purpose: shared constants and carriers for the dual pipelined converter
//          output port.
// Assumes: one converter clock, 100 MHz.
// Notes: stage codes are 2-bit redundant digits in -1..+1.
package dapo_pkg;

	// ==========================================================
	// sizes and timing
	localparam int DAPO_WIDTH = 10;
	localparam int DAPO_STAGES = 9;
	// samples advance one stage per half cycle; the register that takes
	// the sample and four more carry the nine stages, and the output
	// register loads on the fifth edge after the sample edge
	localparam int DAPO_LATENCY_CYCLES = 5;
	localparam int DAPO_PIPE_CYCLES = DAPO_LATENCY_CYCLES;
	localparam logic [9:0] DAPO_ZERO_CODE = 10'h200;
	localparam logic [9:0] DAPO_OUT_RESET = 10'h000;
	localparam logic [1:0] DAPO_DIGIT_RESET = 2'h1;

	// ==========================================================
	// carriers
	// one stage digit: 0 = -1, 1 = 0, 2 = +1 (1.5-bit partial code)
	typedef logic [1:0] dapo_digit_t;
	typedef dapo_digit_t [DAPO_STAGES-1:0] dapo_digits_t;

	typedef struct packed {
		logic [9:0] chan_a;
		logic [9:0] chan_b;
	} dapo_pair_t;

endpackage : dapo_pkg

// ### dapo_corrector.sv
// Purpose: digital error correction for one channel.
// Assumes: digits arrive first stage first in index 8.
// Notes: purely combinational.
`timescale 1ns/10ps
module dapo_corrector (
	input wire dapo_pkg::dapo_digits_t digits_in,
	output logic [9:0] code_out
);

	// ==========================================================
	// overlap-add of redundant digits
	// each stage weighs half the one before; summing signed digits
	// absorbs comparator offsets, so no code is skipped
	logic signed [11:0] acc;
	always_comb begin
		acc = 12'sh000;
		for (int i = 0; i < dapo_pkg::DAPO_STAGES; i++) begin
			acc = acc + ((12'(signed'({1'b0, digits_in[i]})) - 12'sh001)
				<<< i);
		end
		acc = acc + 12'(signed'({1'b0, dapo_pkg::DAPO_ZERO_CODE}));
		if (acc < 12'sh000)
			code_out = 10'h000;
		else if (acc > 12'sh3ff)
			code_out = 10'h3ff;
		else
			code_out = acc[9:0];
	end

endmodule : dapo_corrector

// ### dapo_port.sv
// Purpose: digital side of a dual pipelined converter: stage digits in,
//          two three-state 10-bit words out.
// Assumes: stage digits for a sample are presented with the rising edge
//          that takes the sample; format pin is static.
// Notes: no reset on the device itself; rst_in only sets a known start.
`timescale 1ns/10ps

module dapo_port (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire dapo_pkg::dapo_digits_t chan_a_digits_in,
	input wire dapo_pkg::dapo_digits_t chan_b_digits_in,
	input wire logic twos_comp_sel_in,
	input wire logic output_enable_n_in,
	input wire logic power_down_request_in,
	output logic [9:0] chan_a_out,
	output logic [9:0] chan_a_oe_out,
	output logic [9:0] chan_b_out,
	output logic [9:0] chan_b_oe_out
);

	// ==========================================================
	// state
	typedef struct packed {
		dapo_pkg::dapo_digits_t [dapo_pkg::DAPO_PIPE_CYCLES-1:0] pipe_a;
		dapo_pkg::dapo_digits_t [dapo_pkg::DAPO_PIPE_CYCLES-1:0] pipe_b;
		dapo_pkg::dapo_pair_t word;
		logic [9:0] oe_a;
		logic [9:0] oe_b;
	} dapo_state_t;

	// one channel's whole-cycle pipeline: index 0 is the register that
	// takes the sample on its edge, the last index feeds the corrector
	typedef dapo_pkg::dapo_digits_t [dapo_pkg::DAPO_PIPE_CYCLES-1:0]
		dapo_pipe_t;

	// every stage at its middle digit reads as bipolar zero, so a pipe
	// fresh out of reset walks zero codes to the pins, not garbage
	localparam dapo_pkg::dapo_digits_t DIGITS_IDLE =
		{dapo_pkg::DAPO_STAGES{dapo_pkg::DAPO_DIGIT_RESET}};
	localparam dapo_pipe_t PIPE_IDLE =
		{dapo_pkg::DAPO_PIPE_CYCLES{DIGITS_IDLE}};

	// ==========================================================
	// timing walk of one sample
	// edge 0: digits of the sample land in pipe index 0
	// edges 1 to 4: the digits move one index per edge
	// between edges 4 and 5: the corrector merges the last index
	// edge 5: the output register loads the formatted code
	// the nine half-cycle stages are folded into whole-cycle steps;
	// only the edge on which a code reaches the pins is visible, so
	// nothing finer than a clock edge is kept

	dapo_state_t state_reg;
	dapo_state_t state_next;
	logic [9:0] code_a;
	logic [9:0] code_b;

	// ==========================================================
	// correction of the digits leaving the pipeline
	dapo_corrector u_corr_a (
		.digits_in(state_reg.pipe_a[dapo_pkg::DAPO_PIPE_CYCLES-1]),
		.code_out(code_a)
	);

	dapo_corrector u_corr_b (
		.digits_in(state_reg.pipe_b[dapo_pkg::DAPO_PIPE_CYCLES-1]),
		.code_out(code_b)
	);

	// msb flip converts offset binary to two's complement
	function automatic logic [9:0] dapo_format(input logic [9:0] code,
		input logic twos);
		dapo_format = {code[9] ^ twos, code[8:0]};
	endfunction : dapo_format

	// one whole-cycle step of a channel's pipeline: new digits enter at
	// index 0 and every older entry moves one place on
	function automatic dapo_pipe_t dapo_shift(input dapo_pipe_t pipe,
		input dapo_pkg::dapo_digits_t digits);
		dapo_pipe_t moved;
		moved = pipe;
		moved[0] = digits;
		for (int i = 1; i < dapo_pkg::DAPO_PIPE_CYCLES; i++) begin
			moved[i] = pipe[i-1];
		end
		return moved;
	endfunction : dapo_shift

	// the output register either takes the new formatted code or keeps
	// what the pins show; the pipe keeps running during a hold, so the
	// first word after power-down is already a fresh sample
	function automatic logic [9:0] dapo_pick(input logic [9:0] old_word,
		input logic [9:0] code,
		input logic twos,
		input logic hold);
		logic [9:0] picked;
		picked = old_word;
		if (!hold) begin
			picked = dapo_format(code, twos);
		end
		return picked;
	endfunction : dapo_pick

	// per-bit drive enable for one word; the pins float while the
	// active-low enable is high
	function automatic logic [9:0] dapo_drive(input logic enable_n);
		dapo_drive = {10{~enable_n}};
	endfunction : dapo_drive

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		state_next.pipe_a = dapo_shift(state_reg.pipe_a, chan_a_digits_in);
		state_next.pipe_b = dapo_shift(state_reg.pipe_b, chan_b_digits_in);
		// both words load on the same edge from the same controls
		state_next.word.chan_a = dapo_pick(state_reg.word.chan_a, code_a,
			twos_comp_sel_in, power_down_request_in);
		state_next.word.chan_b = dapo_pick(state_reg.word.chan_b, code_b,
			twos_comp_sel_in, power_down_request_in);
		state_next.oe_a = dapo_drive(output_enable_n_in);
		state_next.oe_b = dapo_drive(output_enable_n_in);
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg.pipe_a <= PIPE_IDLE;
			state_reg.pipe_b <= PIPE_IDLE;
			state_reg.word.chan_a <= dapo_pkg::DAPO_OUT_RESET;
			state_reg.word.chan_b <= dapo_pkg::DAPO_OUT_RESET;
			state_reg.oe_a <= 10'h000;
			state_reg.oe_b <= 10'h000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign chan_a_out = state_reg.word.chan_a;
	assign chan_b_out = state_reg.word.chan_b;
	assign chan_a_oe_out = state_reg.oe_a;
	assign chan_b_oe_out = state_reg.oe_b;

endmodule : dapo_port

// ### dapo_port_checker.sv
// Purpose: port checks
// Assumes: one clock
// Notes: digits 3ffff never match
`timescale 1ns/10ps
module dapo_port_checker (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire dapo_pkg::dapo_digits_t chan_a_digits_in,
	input wire dapo_pkg::dapo_digits_t chan_b_digits_in,
	input wire logic twos_comp_sel_in,
	input wire logic output_enable_n_in,
	input wire logic power_down_request_in,
	input wire logic [9:0] chan_a_out,
	input wire logic [9:0] chan_a_oe_out,
	input wire logic [9:0] chan_b_out,
	input wire logic [9:0] chan_b_oe_out
);
	// ====
	// checks
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	property p_code(logic [17:0] d, logic [9:0] w, logic [17:0] v,
		logic [9:0] c);
		$past(d, 6) == v && !$past(power_down_request_in)
		|-> w == {c[9] ^ $past(twos_comp_sel_in), c[8:0]};
	endproperty
	a_zero_a: assert property (p_code(chan_a_digits_in, chan_a_out,
		18'h15555, 10'h200)) else $error("zero code");
	a_top_b: assert property (p_code(chan_b_digits_in, chan_b_out,
		18'h2aaaa, 10'h3ff)) else $error("top code");
	a_low_a: assert property (p_code(chan_a_digits_in, chan_a_out,
		18'h00000, 10'h001)) else $error("low code a");
	a_low_b: assert property (p_code(chan_b_digits_in, chan_b_out,
		18'h00000, 10'h001)) else $error("low code b");
	a_hold_a: assert property (power_down_request_in |=>
		$stable(chan_a_out)) else $error("a word moved");
	a_hold_b: assert property (power_down_request_in |=>
		$stable(chan_b_out)) else $error("b word moved");
	a_oe_follow: assert property (1 |=> chan_a_oe_out ==
		{10{~$past(output_enable_n_in)}}) else $error("oe late");
	a_oe_pair: assert property (chan_a_oe_out == chan_b_oe_out)
		else $error("oe split");
	cover property (power_down_request_in ##1 !power_down_request_in);
	cover property (output_enable_n_in);
	cover property (twos_comp_sel_in && chan_a_out == 10'h000);
endmodule : dapo_port_checker
bind dapo_port dapo_port_checker chk (.*);

// ### dapo_sink.sv
// Purpose: capturing logic model
// Assumes: pins sampled on rising edge
// Notes: a floating pin shows its inverse
`timescale 1ns/10ps
module dapo_sink (
	input wire logic clk_in,
	input wire dapo_pkg::dapo_pair_t word_in,
	input wire dapo_pkg::dapo_pair_t oe_in,
	output dapo_pkg::dapo_pair_t pin_out
);
	dapo_pkg::dapo_pair_t last_reg = '0;
	// so a float never passes for a match
	assign pin_out = (word_in & oe_in) | (~last_reg & ~oe_in);
	always_ff @(posedge clk_in) last_reg <= pin_out;
endmodule : dapo_sink

// ### dapo_port_bench.sv
// Purpose: stream bench
// Assumes: 100 MHz clock
// Notes: random digit streams
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
$display("[ERR] %0t %h %h", $time, a, b); end end
module dapo_port_bench;
	logic ref_clk_in = 0, rst_in = 1, twos = 0, oen = 0, pd = 0;
	dapo_pkg::dapo_digits_t da = 18'h3ffff, db = 18'h3ffff;
	logic [9:0] qa, qb, ea, eb;
	dapo_pkg::dapo_pair_t q[$], last, e, pin;
	int bad_count = 0, n_checks = 0;
	dapo_port dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.chan_a_digits_in(da), .chan_b_digits_in(db),
		.twos_comp_sel_in(twos), .output_enable_n_in(oen),
		.power_down_request_in(pd), .chan_a_out(qa),
		.chan_a_oe_out(ea), .chan_b_out(qb), .chan_b_oe_out(eb));
	dapo_sink sink (.clk_in(ref_clk_in), .word_in({qa, qb}),
		.oe_in({ea, eb}), .pin_out(pin));
	function automatic logic [9:0] cv(dapo_pkg::dapo_digits_t d);
		int s;
		s = 512;
		for (int i = 0; i < 9; i++) s += (int'(d[i]) - 1) << i;
		return s > 1023 ? 10'h3ff : 10'(s);
	endfunction : cv
	function automatic dapo_pkg::dapo_digits_t gen();
		dapo_pkg::dapo_digits_t g;
		int k;
		k = $urandom_range(0, 3);
		for (int i = 0; i < 9; i++)
			g[i] = 2'(k == 0 ? $urandom_range(0, 2) : k - 1);
		return g;
	endfunction : gen
	task test_done;
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task run(input logic t, p, o);
		repeat (50) begin
			@(negedge ref_clk_in);
			twos = t;
			pd = p & 1'($urandom_range(0, 1));
			oen = o & 1'($urandom_range(0, 1));
			da = gen();
			db = gen();
			q.push_back('{cv(da), cv(db)});
		end
	endtask : run
	initial forever #5 ref_clk_in = ~ref_clk_in;
	initial begin
		#20us;
		bad_count++;
		test_done;
	end
	// ====
	// monitor: pd and format count at the loading edge
	always @(posedge ref_clk_in) begin
		#1;
		if (q.size() > 5) begin
			e = q.pop_front();
			e.chan_a[9] ^= twos;
			e.chan_b[9] ^= twos;
			if (pd) e = last;
			last = e;
			if (oen) `CHK({ea, eb}, 20'h00000)
			else `CHK(pin, e)
		end
	end
	initial begin
		void'($urandom(68));
		repeat (20) @(posedge ref_clk_in);
		@(negedge ref_clk_in) rst_in = 0;
		for (int i = 0; i < 4; i++) begin
			run(i[0], i[1], i == 3);
			$display("test %0d done", i);
		end
		test_done;
	end
endmodule : dapo_port_bench
